/* File: common/assm_pkg.sv */
// Constants and types shared by the audio serial slot mapper.
// Assumes a single 50 MHz core clock and an Avalon-MM register master.
`default_nettype none

package assm_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;
  localparam int SAMPLE_W = 32;
  localparam int CNT_W = 11;
  localparam int OFFSET_W = 5;
  localparam int CFG_W = 7;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_CHAN_ONE = 6'h0b;
  localparam logic [5:0] IDX_CHAN_TWO = 6'h0c;
  localparam logic [5:0] IDX_CHAN_THREE = 6'h0d;
  localparam logic [5:0] IDX_FRAME_CFG = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LINE_SEL_BIT = 6;
  localparam int SLOT_MSB = 5;
  localparam int OFFSET_LSB = 0;
  localparam int FILL_BIT = 5;
  localparam int FMT_LSB = 6;
  localparam int STAT_RUN_BIT = 7;
  localparam int STAT_RIGHT_BIT = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [CFG_W-1:0] CHAN_ONE_RESET = 7'h00;
  localparam logic [CFG_W-1:0] CHAN_TWO_RESET = 7'h01;
  localparam logic [CFG_W-1:0] CHAN_THREE_RESET = 7'h02;
  localparam logic [7:0] FRAME_CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    ASSM_FMT_TDM = 2'h0,
    ASSM_FMT_I2S = 2'h1,
    ASSM_FMT_LEFT_JUSTIFIED = 2'h2
  } assm_fmt_t;

  typedef enum logic [1:0] {
    ASSM_SER_IDLE = 2'h0,
    ASSM_SER_RUN = 2'h1
  } assm_ser_t;

endpackage

`default_nettype wire

/* File: core/assm_pin_sync.sv */
// Two-stage synchroniser for the bit clock and frame sync pins.
// Assumes both pins come from the far end, unrelated to the core clock.
`timescale 1ns/1ps
`default_nettype none

module assm_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_clock_pin,
  input wire logic frame_sync_pin,
  output logic bit_clock_fall,
  output logic frame_sync_level
);

  typedef struct packed {
    logic [1:0] stage_one;
    logic [1:0] stage_two;
    logic bclk_prev;
  } assm_sync_state_t;

  assm_sync_state_t q;
  assm_sync_state_t d;

  always_comb begin
    d = q;
    d.stage_one = {frame_sync_pin, bit_clock_pin};
    d.stage_two = q.stage_one;
    d.bclk_prev = q.stage_two[0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Both pins see the same latency so frame sync stays aligned to edges
  assign bit_clock_fall = q.bclk_prev & ~q.stage_two[0];
  assign frame_sync_level = q.stage_two[1];

endmodule

`default_nettype wire

/* File: core/assm_slot_mapper.sv */
// Slot and output-line mapper for three audio serial transmit channels.
// Assumes an Avalon-MM master on the core clock and a far-end bit clock
// and frame sync that are sampled through a two-stage synchroniser.
//
// Overview of operation
// - Bit 6 picks primary or secondary line
// - Slot values 0-31: TDM or left slot
// - Slot values 32-63: TDM or right slot
// - Channel one slot resets to zero
// - Channel two slot resets to one
// - Channel three slot resets to two
// - Channel one, two line select reset zero
// - Unused cycles send zero or high impedance
// - Slot zero MSB offset on both lines
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module assm_slot_mapper (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [assm_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [assm_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [assm_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic BIT_CLOCK_IN,
  input wire logic FRAME_SYNC_IN,
  input wire logic [assm_pkg::SAMPLE_W-1:0] SAMPLE_CHAN_ONE,
  input wire logic [assm_pkg::SAMPLE_W-1:0] SAMPLE_CHAN_TWO,
  input wire logic [assm_pkg::SAMPLE_W-1:0] SAMPLE_CHAN_THREE,
  output logic FRAME_START,
  output logic PRIMARY_SERIAL_OUTPUT_OUT,
  output logic PRIMARY_SERIAL_OUTPUT_OE,
  output logic SECONDARY_OUTPUT_PIN_A_OUT,
  output logic SECONDARY_OUTPUT_PIN_A_OE,
  output logic SECONDARY_OUTPUT_PIN_B_OUT,
  output logic SECONDARY_OUTPUT_PIN_B_OE
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic waitreq;
    logic [assm_pkg::DATA_W-1:0] rdata;
    logic [assm_pkg::NUM_CH-1:0][assm_pkg::CFG_W-1:0] cfg;
    logic [7:0] frame_cfg;
    logic [assm_pkg::NUM_CH-1:0][assm_pkg::SAMPLE_W-1:0] hold;
    assm_pkg::assm_ser_t ser;
    logic [assm_pkg::CNT_W-1:0] cnt;
    logic right;
    logic fs_prev;
    logic [5:0] cur_field;
    logic frame_start;
    logic pri_out;
    logic pri_oe;
    logic sec_out;
    logic sec_oe;
  } assm_core_state_t;

  assm_core_state_t q;
  assm_core_state_t d;

  logic bclk_fall;
  logic fsync;

  assm_pin_sync u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .bit_clock_pin(BIT_CLOCK_IN),
    .frame_sync_pin(FRAME_SYNC_IN),
    .bit_clock_fall(bclk_fall),
    .frame_sync_level(fsync)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] reg_byte(
    input logic [5:0] idx,
    input assm_core_state_t s
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      assm_pkg::IDX_CHAN_ONE: v = {1'b0, s.cfg[0]};
      assm_pkg::IDX_CHAN_TWO: v = {1'b0, s.cfg[1]};
      assm_pkg::IDX_CHAN_THREE: v = {1'b0, s.cfg[2]};
      assm_pkg::IDX_FRAME_CFG: v = s.frame_cfg;
      assm_pkg::IDX_STATUS: begin
        v[assm_pkg::STAT_RUN_BIT] = (s.ser == assm_pkg::ASSM_SER_RUN);
        v[assm_pkg::STAT_RIGHT_BIT] = s.right;
        v[assm_pkg::SLOT_MSB:0] = s.cur_field;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic slot_hit(
    input logic [assm_pkg::CFG_W-1:0] cfg,
    input logic [5:0] field
  );
    return cfg[assm_pkg::SLOT_MSB:0] == field;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic [5:0] idx;
  logic aligned;
  logic [1:0] fmt;
  logic [assm_pkg::OFFSET_W-1:0] offset;
  logic fill_hiz;
  logic fs_rise;
  logic fs_fall;
  logic start_left;
  logic start_right;
  logic half_start;
  logic dly;
  logic right_now;
  logic [assm_pkg::CNT_W-1:0] praw;
  logic [assm_pkg::CNT_W-1:0] lead;
  logic [assm_pkg::CNT_W-1:0] pos;
  logic pos_valid;
  logic [5:0] field;
  logic hit_p;
  logic hit_s;
  logic bit_p;
  logic bit_s;
  logic bit_c;
  logic [assm_pkg::NUM_CH-1:0][assm_pkg::SAMPLE_W-1:0] samples;

  always_comb begin
    d = q;
    d.frame_start = 1'b0;
    idx = AVS_ADDRESS[7:2];
    aligned = (AVS_ADDRESS[1:0] == 2'h0);
    samples = {SAMPLE_CHAN_THREE, SAMPLE_CHAN_TWO, SAMPLE_CHAN_ONE};

    // Avalon slave: one wait cycle, then answer for exactly one cycle
    if ((AVS_READ || AVS_WRITE) && q.waitreq) begin
      d.waitreq = 1'b0;
      if (AVS_READ) begin
        d.rdata = aligned ? {24'h000000, reg_byte(idx, q)} : 32'h00000000;
      end
    end else if (!q.waitreq) begin
      d.waitreq = 1'b1;
      if (AVS_WRITE && AVS_BYTEENABLE[0] && aligned) begin
        case (idx)
          assm_pkg::IDX_CHAN_ONE: d.cfg[0] = AVS_WRITEDATA[6:0];
          assm_pkg::IDX_CHAN_TWO: d.cfg[1] = AVS_WRITEDATA[6:0];
          assm_pkg::IDX_CHAN_THREE: d.cfg[2] = AVS_WRITEDATA[6:0];
          assm_pkg::IDX_FRAME_CFG: d.frame_cfg = AVS_WRITEDATA[7:0];
          default: d.frame_cfg = q.frame_cfg;
        endcase
      end
    end

    // Frame decode, evaluated at each bit clock falling edge
    fmt = q.frame_cfg[assm_pkg::FMT_LSB +: 2];
    offset = q.frame_cfg[assm_pkg::OFFSET_LSB +: assm_pkg::OFFSET_W];
    fill_hiz = q.frame_cfg[assm_pkg::FILL_BIT];
    fs_rise = fsync & ~q.fs_prev;
    fs_fall = ~fsync & q.fs_prev;
    case (fmt)
      assm_pkg::ASSM_FMT_I2S: begin
        start_left = fs_fall;
        start_right = fs_rise;
        dly = 1'b1;
      end
      assm_pkg::ASSM_FMT_LEFT_JUSTIFIED: begin
        start_left = fs_rise;
        start_right = fs_fall;
        dly = 1'b0;
      end
      default: begin
        start_left = fs_rise;
        start_right = 1'b0;
        dly = 1'b0;
      end
    endcase
    half_start = start_left | start_right;
    right_now = half_start ? start_right : q.right;
    // Counter saturates so a missing frame sync cannot wrap into slot 0
    if (half_start) begin
      praw = '0;
    end else if (q.cnt == {assm_pkg::CNT_W{1'b1}}) begin
      praw = q.cnt;
    end else begin
      praw = q.cnt + 11'h001;
    end
    lead = {5'h00, 1'b0, offset} + {10'h000, dly};
    pos = praw - lead;
    pos_valid = (praw >= lead);
    if (fmt == assm_pkg::ASSM_FMT_I2S ||
        fmt == assm_pkg::ASSM_FMT_LEFT_JUSTIFIED) begin
      field = {right_now, pos[9:5]};
      pos_valid = pos_valid & ~pos[10];
    end else begin
      field = pos[10:5];
    end
    if (q.ser != assm_pkg::ASSM_SER_RUN && !half_start) begin
      pos_valid = 1'b0;
    end

    // Lowest channel wins when two claim the same slot and line
    hit_p = 1'b0;
    hit_s = 1'b0;
    bit_p = 1'b0;
    bit_s = 1'b0;
    for (int c = assm_pkg::NUM_CH - 1; c >= 0; c--) begin
      bit_c = start_left ? samples[c][~pos[4:0]] : q.hold[c][~pos[4:0]];
      if (pos_valid && slot_hit(q.cfg[c], field)) begin
        if (q.cfg[c][assm_pkg::LINE_SEL_BIT]) begin
          hit_s = 1'b1;
          bit_s = bit_c;
        end else begin
          hit_p = 1'b1;
          bit_p = bit_c;
        end
      end
    end

    if (bclk_fall) begin
      d.fs_prev = fsync;
      d.cnt = praw;
      d.right = right_now;
      d.cur_field = pos_valid ? field : 6'h00;
      if (half_start) begin
        d.ser = assm_pkg::ASSM_SER_RUN;
      end
      if (start_left) begin
        d.hold = samples;
        d.frame_start = 1'b1;
      end
      d.pri_out = hit_p & bit_p;
      d.pri_oe = hit_p | ~fill_hiz;
      d.sec_out = hit_s & bit_s;
      d.sec_oe = hit_s | ~fill_hiz;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      q <= '0;
      q.waitreq <= 1'b1;
      q.cfg[0] <= assm_pkg::CHAN_ONE_RESET;
      q.cfg[1] <= assm_pkg::CHAN_TWO_RESET;
      q.cfg[2] <= assm_pkg::CHAN_THREE_RESET;
      q.frame_cfg <= assm_pkg::FRAME_CFG_RESET;
      q.ser <= assm_pkg::ASSM_SER_IDLE;
    end else begin
      q <= d;
    end
  end

  assign AVS_READDATA = q.rdata;
  assign AVS_WAITREQUEST = q.waitreq;
  assign FRAME_START = q.frame_start;
  assign PRIMARY_SERIAL_OUTPUT_OUT = q.pri_out;
  assign PRIMARY_SERIAL_OUTPUT_OE = q.pri_oe;
  // Both secondary pins carry the same line; pin muxing lives elsewhere
  assign SECONDARY_OUTPUT_PIN_A_OUT = q.sec_out;
  assign SECONDARY_OUTPUT_PIN_A_OE = q.sec_oe;
  assign SECONDARY_OUTPUT_PIN_B_OUT = q.sec_out;
  assign SECONDARY_OUTPUT_PIN_B_OE = q.sec_oe;

endmodule

`default_nettype wire

/* File: dv/assm_checker.sv */
// Port-level checks on the slot mapper.
// Assumes a bind onto assm_slot_mapper; one clock, sync reset.
`timescale 1ns/1ps
`default_nettype none

module assm_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic FRAME_START,
  input wire logic PRIMARY_SERIAL_OUTPUT_OE,
  input wire logic SECONDARY_OUTPUT_PIN_A_OUT,
  input wire logic SECONDARY_OUTPUT_PIN_A_OE,
  input wire logic SECONDARY_OUTPUT_PIN_B_OUT,
  input wire logic SECONDARY_OUTPUT_PIN_B_OE
);
  // **********
  // Checks
  // **********
  logic req;
  logic rd_ok;
  logic mapped;
  assign req = AVS_READ | AVS_WRITE;
  assign rd_ok = AVS_READ & ~AVS_WAITREQUEST;
  assign mapped = AVS_ADDRESS[1:0] == 2'h0 &&
    AVS_ADDRESS[7:2] inside {6'h0b, 6'h0c, 6'h0d, 6'h20, 6'h21};
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  wait_answer_a: assert property (req && AVS_WAITREQUEST |=>
    !AVS_WAITREQUEST) else $error("late answer");
  wait_single_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("long answer");
  wait_idle_a: assert property (!req |=> AVS_WAITREQUEST)
    else $error("answer with no request");
  rsvd_bit_a: assert property (rd_ok &&
    AVS_ADDRESS inside {8'h2c, 8'h30, 8'h34} |-> !AVS_READDATA[7])
    else $error("reserved bit set");
  unmapped_a: assert property (rd_ok && !mapped |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  sec_copy_a: assert property (
    {SECONDARY_OUTPUT_PIN_A_OUT, SECONDARY_OUTPUT_PIN_A_OE} ==
    {SECONDARY_OUTPUT_PIN_B_OUT, SECONDARY_OUTPUT_PIN_B_OE})
    else $error("secondary pins differ");
  rst_quiet_a: assert property ($fell(RST) |-> AVS_WAITREQUEST &&
    !PRIMARY_SERIAL_OUTPUT_OE && !SECONDARY_OUTPUT_PIN_A_OE)
    else $error("active after reset");
  fs_pulse_a: assert property (FRAME_START |=> !FRAME_START)
    else $error("long frame start");
endmodule
`default_nettype wire

/* File: dv/assm_far_end.sv */
// Far-end receiver: makes bit clock and frame sync, captures bits.
// Assumes the core clock; 2048-bit frames, sync high in first half.
`timescale 1ns/1ps
`default_nettype none

module assm_far_end (
  input wire logic clk,
  input wire logic en,
  input wire logic pri,
  input wire logic pri_oe,
  input wire logic sec,
  input wire logic sec_oe,
  output logic bclk,
  output logic fsync,
  output logic done,
  output logic [2047:0] rxp,
  output logic [2047:0] rxz,
  output logic [2047:0] rxs
);
  // **********
  // Link timing
  // **********
  logic [3:0] ph;
  logic [11:0] pos;
  // Six cycles per phase; clock stands low between frames
  assign bclk = ph >= 4'h6;
  assign fsync = pos[11:10] == 2'h0;
  assign done = pos == 12'h7ff && ph == 4'hb;
  always_ff @(posedge clk) begin
    if (!en) begin
      ph <= 4'h0;
      pos <= 12'hfff;
    end else begin
      ph <= ph == 4'hb ? 4'h0 : ph + 4'h1;
      if (ph == 4'hb) begin
        pos <= pos + 12'h1;
      end
      // Sample late in the high phase, long after lines settle
      if (ph == 4'ha) begin
        // A released line floats; show the inverse so a missing drive
        // cannot pass for the expected level
        rxp[pos[10:0]] <= pri_oe ? pri : ~pri;
        rxz[pos[10:0]] <= pri_oe;
        rxs[pos[10:0]] <= sec_oe ? sec : ~sec;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench for the slot mapper.
// Assumes the checker and far-end model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [31:0] S1 = 32'hc3a5_0f96;
  localparam logic [31:0] S2 = 32'h5a3c_e187;
  localparam logic [31:0] S3 = 32'h9e01_7bd4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic en = 1'b0;
  logic flip = 1'b0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h1;
  logic [31:0] rdata;
  logic wait_rq, bclk, fsync, done, po, poe, sa, soe, fstart;
  logic [2047:0] rxp, rxz, rxs;
  int bad_count = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  assm_slot_mapper uut (
    .CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq),
    .BIT_CLOCK_IN(bclk), .FRAME_SYNC_IN(fsync),
    .SAMPLE_CHAN_ONE(S1 ^ {32{flip}}), .SAMPLE_CHAN_TWO(S2 ^ {32{flip}}),
    .SAMPLE_CHAN_THREE(S3 ^ {32{flip}}), .FRAME_START(fstart),
    .PRIMARY_SERIAL_OUTPUT_OUT(po), .PRIMARY_SERIAL_OUTPUT_OE(poe),
    .SECONDARY_OUTPUT_PIN_A_OUT(sa), .SECONDARY_OUTPUT_PIN_A_OE(soe),
    .SECONDARY_OUTPUT_PIN_B_OUT(), .SECONDARY_OUTPUT_PIN_B_OE());

  assm_far_end far (.clk(clk), .en(en), .pri(po), .pri_oe(poe),
    .sec(sa), .sec_oe(soe), .bclk(bclk), .fsync(fsync), .done(done),
    .rxp(rxp), .rxz(rxz), .rxs(rxs));

  // **********
  // Tasks
  // **********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d bad %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Request holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [7:0] d, input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    q = rdata;
    if (wait_rq !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t bus timeout", $time);
      close_out();
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rdck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h0, 4'h1, q);
    chk(q, e);
  endtask

  // Runs one whole frame of 2048 bit clocks; the sample words change
  // right after the capture pulse, so a late or stale capture shows up
  task automatic frame();
    int n;
    int k;
    n = 0;
    k = 0;
    en <= 1'b1;
    flip <= 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (fstart === 1'b1) begin
        k++;
        flip <= 1'b1;
      end
    end while (done !== 1'b1 && n < 30000);
    if (done !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t frame timeout", $time);
      close_out();
    end
    chk(32'(k), 32'h1);
    en <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] word(input logic [2047:0] v, input int b);
    for (int i = 0; i < 32; i++) begin
      word[31 - i] = v[b + i];
    end
  endfunction

  task automatic t_regs();
    logic [31:0] q;
    rdck(8'h2c, 32'h0);
    rdck(8'h30, 32'h1);
    rdck(8'h34, 32'h2);
    wr8(8'h34, 8'hff);
    rdck(8'h34, 32'h7f);
    bus(1'b1, 8'h30, 8'h55, 4'h0, q);
    rdck(8'h30, 32'h1);
    wr8(8'h40, 8'h33);
    rdck(8'h40, 32'h0);
    $display("registers done");
  endtask

  task automatic t_tdm();
    wr8(8'h30, 8'h61);
    wr8(8'h34, 8'h3f);
    wr8(8'h80, 8'h20);
    frame();
    chk(word(rxp, 0), S1);
    chk(word(rxs, 1056), S2);
    chk(word(rxp, 2016), S3);
    chk({31'h0, rxz[1056]}, 32'h0);
    chk({31'h0, rxz[160]}, 32'h0);
    chk({31'h0, rxs[160]}, 32'h1);
    rdck(8'h84, 32'hbf);
    $display("tdm done");
  endtask

  task automatic t_left_just();
    wr8(8'h2c, 8'h20);
    wr8(8'h30, 8'h41);
    wr8(8'h80, 8'h83);
    frame();
    chk(word(rxp, 1027), S1);
    chk(word(rxs, 35), S2);
    chk({30'h0, rxz[0], rxp[0]}, 32'h2);
    chk({31'h0, rxs[0]}, 32'h0);
    $display("left-justified done");
  endtask

  task automatic t_i2s();
    wr8(8'h34, 8'h00);
    wr8(8'h80, 8'h40);
    frame();
    chk(word(rxp, 1), S1);
    chk(word(rxp, 1025), S3);
    chk(word(rxs, 1057), S2);
    $display("i2s done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tdm();
    t_left_just();
    t_i2s();
    close_out();
  end
endmodule

bind assm_slot_mapper assm_checker chk_i (.CORE_CLK(CORE_CLK), .RST(RST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .FRAME_START(FRAME_START),
  .PRIMARY_SERIAL_OUTPUT_OE(PRIMARY_SERIAL_OUTPUT_OE),
  .SECONDARY_OUTPUT_PIN_A_OUT(SECONDARY_OUTPUT_PIN_A_OUT),
  .SECONDARY_OUTPUT_PIN_A_OE(SECONDARY_OUTPUT_PIN_A_OE),
  .SECONDARY_OUTPUT_PIN_B_OUT(SECONDARY_OUTPUT_PIN_B_OUT),
  .SECONDARY_OUTPUT_PIN_B_OE(SECONDARY_OUTPUT_PIN_B_OE));
`default_nettype wire
